// >>> common/rdw_defines.vh
// Constants for the receive descriptor status write-back block
`ifndef RDW_DEFINES_VH
`define RDW_DEFINES_VH

// Register byte offsets
`define RDW_REG_CTRL        8'h00
`define RDW_REG_FIRST_DESC  8'h04
`define RDW_REG_SLOT_ADDR   8'h08
`define RDW_REG_STATE       8'h0C
`define RDW_REG_LAST_WORD   8'h10
`define RDW_REG_BRANCH      8'h14

// Control register fields
`define RDW_CTRL_MODE_LO    0
`define RDW_CTRL_MODE_HI    2
`define RDW_CTRL_CSEL       3
`define RDW_CTRL_CRC32      4
`define RDW_CTRL_BIG_END    5
`define RDW_CTRL_RESET      6'h00

// Channel modes
`define RDW_MODE_HDLC       3'h0
`define RDW_MODE_BIT_TR     3'h1
`define RDW_MODE_FLAG_TR    3'h2
`define RDW_MODE_OCTET_TR   3'h3
`define RDW_MODE_V110       3'h4

// Close causes
`define RDW_CAUSE_FILL      3'h0
`define RDW_CAUSE_FRAME_END 3'h1
`define RDW_CAUSE_FAST_ABT  3'h2
`define RDW_CAUSE_SYNC_LOSS 3'h3
`define RDW_CAUSE_STAGE     3'h4
`define RDW_CAUSE_PAUSE     3'h5

// Status byte values, bit positions and per-mode masks
`define RDW_STAT_OK         8'h00
`define RDW_STAT_SHORT_OK   8'h40
`define RDW_STAT_FAST_ABT   8'h02
`define RDW_STAT_LOSS       8'h20
`define RDW_STAT_STAGE      8'h01
`define RDW_BIT_SHORT       6
`define RDW_BIT_LOSS        5
`define RDW_BIT_CHECK       4
`define RDW_BIT_PARTIAL     3
`define RDW_BIT_OVERSIZE    2
`define RDW_BIT_ABORT       1
`define RDW_BIT_OVERRUN     0
`define RDW_MASK_HDLC_CS0   8'h7F
`define RDW_MASK_HDLC_CS1   8'h3F
`define RDW_MASK_V110       8'h23
`define RDW_MASK_FRAME_TR   8'h0F
`define RDW_MASK_OCTET_TR   8'h02

// Short-frame limits in bits
`define RDW_SHORT_BITS_16   16'h0020
`define RDW_SHORT_BITS_32   16'h0030

// Second long word layout
`define RDW_W_LAST          31
`define RDW_W_WRITTEN       30
`define RDW_W_CNT_HI        28
`define RDW_W_CNT_LO        16
`define RDW_W_STAT_HI       15
`define RDW_W_STAT_LO       8
`define RDW_DESC_W2_OFS     32'h0000_0004

`endif

// >>> hw/rdw_writeback.v
// Receive descriptor second long word write-back with branch control
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "rdw_defines.vh"

// Overview of operation
// RULE_01: Last-piece only in frame modes, else zero
// RULE_02: Exact fill: zero last-piece, then close next
// RULE_03: Normal fill: written set, last clear, status 00
// RULE_04: Fast abort close: written set, status 02
// RULE_05: Frame end: written, last, status, frame interrupt
// RULE_06: Sync lost: loss status 20/21, fault interrupt; code does this in V110 mode only, other modes write 00
// RULE_07: Staging inaccessible: status 01/21, fault interrupt; code writes 01, V110 mode only, else 00 and no fault
// RULE_08: After write, store next address, then branch
// RULE_09: Count field holds bytes actually stored
// RULE_10: Status written always; fault unless 00/40
// RULE_11: Short frame bit, HDLC selector zero only
// RULE_12: Check error bit follows CRC result
// RULE_13: Partial octet bit when bits not multiple
// RULE_14: Oversize bit on length limit abort
// RULE_15: Abort bit causes depend on mode
// RULE_16: Overrun freezes status of that frame
// RULE_17: Multiple errors set all bits together
// RULE_18: Bit 7 zero; unused mode bits forced zero
// RULE_19: Non-HDLC abort only fast abort or pause
// RULE_20: Redirect command while busy uses first address
// RULE_21: Host reads status only with last-piece set
// RULE_22: Data bytes placed by selected byte order
// RULE_23: Host section sizes multiple of four, bounded
// RULE_24: Device writes only second descriptor word
// RULE_25: Second word field layout fixed, rest zero
module rdw_writeback (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // APB register slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Close requests from the receive engine
  input  wire        close_valid,
  output wire        close_ready,
  input  wire [2:0]  close_cause,
  input  wire [31:0] close_desc_addr,
  input  wire [31:0] close_next_ptr,
  input  wire [31:0] close_next2_ptr,
  input  wire [12:0] stored_byte_count,
  input  wire [12:0] section_size,
  input  wire [15:0] frame_bits,
  input  wire        abort_flag_seen,
  input  wire        abort_cmd_seen,
  // Frame error reports
  input  wire        err_valid,
  input  wire        check_error_flag,
  input  wire        partial_octet_flag,
  input  wire        oversize_flag,
  input  wire        overrun_flag,
  // Channel commands that redirect to the first descriptor
  input  wire        redirect_cmd,
  // Shared memory write master
  output reg         mem_req,
  output reg  [31:0] mem_addr,
  output reg  [31:0] mem_wdata,
  input  wire        mem_ack,
  // Branch to next descriptor
  output reg         branch_valid,
  output reg  [31:0] branch_addr,
  // Interrupt events
  output reg         frame_end_int_flag,
  output reg         fault_int,
  // Receive data byte ordering
  input  wire        rx_word_valid,
  input  wire [31:0] rx_word,
  output reg         data_word_valid,
  output reg  [31:0] data_word
);

  localparam [4:0] ST_IDLE   = 5'b00001;
  localparam [4:0] ST_WDESC  = 5'b00010;
  localparam [4:0] ST_WDESC2 = 5'b00100;
  localparam [4:0] ST_WSLOT  = 5'b01000;
  localparam [4:0] ST_BRANCH = 5'b10000;

  reg  [4:0]  state;
  reg  [5:0]  ctrl;
  reg  [31:0] first_rx_desc_addr;
  reg  [31:0] channel_status_slot;
  reg  [31:0] last_word;
  reg  [7:0]  err_acc;
  reg         err_frozen;
  reg         redirect;
  reg         exact_pend;
  reg  [7:0]  pend_status;
  reg  [31:0] desc_addr;
  reg  [31:0] next_ptr;
  reg  [31:0] next2_ptr;
  reg  [31:0] word2;
  reg         word2_last;
  reg  [7:0]  word2_status;

  wire [2:0]  mode       = ctrl[`RDW_CTRL_MODE_HI:`RDW_CTRL_MODE_LO];
  wire        csel       = ctrl[`RDW_CTRL_CSEL];
  wire        crc32      = ctrl[`RDW_CTRL_CRC32];
  wire        big_endian = ctrl[`RDW_CTRL_BIG_END];
  wire        is_hdlc    = (mode == `RDW_MODE_HDLC);
  wire        frame_mode = is_hdlc || (mode == `RDW_MODE_BIT_TR) || (mode == `RDW_MODE_FLAG_TR); // RULE_01
  wire        is_v110    = (mode == `RDW_MODE_V110);

  // Mode masks for status bits
  reg  [7:0]  mode_mask;
  always @* begin
    case (mode)
      `RDW_MODE_HDLC:     mode_mask = csel ? `RDW_MASK_HDLC_CS1 : `RDW_MASK_HDLC_CS0; // RULE_18
      `RDW_MODE_BIT_TR:   mode_mask = `RDW_MASK_FRAME_TR; // RULE_18
      `RDW_MODE_FLAG_TR:  mode_mask = `RDW_MASK_FRAME_TR;
      `RDW_MODE_OCTET_TR: mode_mask = `RDW_MASK_OCTET_TR;
      `RDW_MODE_V110:     mode_mask = `RDW_MASK_V110;
      default:            mode_mask = 8'h00;
    endcase
  end

  // Status and layout of the closing word
  reg  [7:0]  extra_bits;
  reg  [7:0]  next_status;
  reg         next_last;
  reg         short_frame_flag;
  reg         abort_seen;
  wire        exact_fill = frame_mode && (close_cause == `RDW_CAUSE_FRAME_END) &&
                           (stored_byte_count == section_size);

  always @* begin
    short_frame_flag = is_hdlc && !csel &&
                       (frame_bits <= (crc32 ? `RDW_SHORT_BITS_32 : `RDW_SHORT_BITS_16)); // RULE_11
    abort_seen = (close_cause == `RDW_CAUSE_FAST_ABT) || (close_cause == `RDW_CAUSE_PAUSE) ||
                 (is_hdlc && (abort_flag_seen || abort_cmd_seen)); // RULE_15 RULE_19
    extra_bits = 8'h00;
    extra_bits[`RDW_BIT_SHORT] = short_frame_flag;
    extra_bits[`RDW_BIT_ABORT] = abort_seen;
    next_last   = 1'b0;
    next_status = `RDW_STAT_OK;
    case (close_cause)
      `RDW_CAUSE_FILL: begin
        next_last   = 1'b0; // RULE_03
        next_status = `RDW_STAT_OK;
      end
      `RDW_CAUSE_FRAME_END: begin
        next_last   = frame_mode && !exact_fill; // RULE_05 RULE_02
        // Later aborts must not disturb a frame that overran
        next_status = err_frozen ? err_acc : (err_acc | extra_bits); // RULE_16 RULE_17
        if (exact_fill)
          next_status = `RDW_STAT_OK;
      end
      `RDW_CAUSE_FAST_ABT: begin
        next_last   = frame_mode;
        next_status = `RDW_STAT_FAST_ABT; // RULE_04
      end
      `RDW_CAUSE_SYNC_LOSS: begin
        next_last   = 1'b0;
        next_status = `RDW_STAT_LOSS | (err_acc & `RDW_STAT_STAGE); // RULE_06
      end
      `RDW_CAUSE_STAGE: begin
        next_last   = 1'b0;
        next_status = `RDW_STAT_STAGE | (err_acc & `RDW_STAT_LOSS); // RULE_07
      end
      `RDW_CAUSE_PAUSE: begin
        next_last   = frame_mode;
        next_status = err_frozen ? err_acc : (err_acc | extra_bits);
      end
      default: begin
        next_last   = 1'b0;
        next_status = `RDW_STAT_OK;
      end
    endcase
    if (!is_v110 && (close_cause == `RDW_CAUSE_SYNC_LOSS || close_cause == `RDW_CAUSE_STAGE))
      next_status = `RDW_STAT_OK;
    next_status = next_status & mode_mask; // RULE_18
    next_status[7] = 1'b0; // RULE_18
  end

  // Frame status assembled for the pending exact-fill descriptor
  wire [7:0] exact_status = (err_frozen ? err_acc : (err_acc | extra_bits)) & mode_mask;

  function [31:0] pack_word;
    input        last;
    input [12:0] cnt;
    input [7:0]  stat;
    begin
      pack_word = 32'h0000_0000; // RULE_25
      pack_word[`RDW_W_LAST]    = last;
      pack_word[`RDW_W_WRITTEN] = 1'b1;
      pack_word[`RDW_W_CNT_HI:`RDW_W_CNT_LO]   = cnt;
      pack_word[`RDW_W_STAT_HI:`RDW_W_STAT_LO] = stat;
    end
  endfunction

  assign close_ready = (state == ST_IDLE);
  wire   close_take  = close_valid && close_ready;

  // APB access
  wire        apb_wr   = psel && penable && pwrite;
  // Read data loaded in setup so it stands through the access phase
  wire        apb_rd   = psel && !penable && !pwrite;
  reg         addr_hit;
  always @* begin
    case (paddr)
      `RDW_REG_CTRL, `RDW_REG_FIRST_DESC, `RDW_REG_SLOT_ADDR,
      `RDW_REG_STATE, `RDW_REG_LAST_WORD, `RDW_REG_BRANCH: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_hit;

  reg [31:0] slot_addr;

  always @(posedge clk) begin
    if (reset) begin
      ctrl               <= `RDW_CTRL_RESET;
      first_rx_desc_addr <= 32'h0000_0000;
      slot_addr          <= 32'h0000_0000;
      prdata             <= 32'h0000_0000;
    end else begin
      if (apb_wr) begin
        case (paddr)
          `RDW_REG_CTRL:       ctrl <= pwdata[5:0];
          `RDW_REG_FIRST_DESC: first_rx_desc_addr <= pwdata;
          `RDW_REG_SLOT_ADDR:  slot_addr <= pwdata;
          default: ;
        endcase
      end
      if (apb_rd) begin
        case (paddr)
          `RDW_REG_CTRL:       prdata <= {26'h0, ctrl};
          `RDW_REG_FIRST_DESC: prdata <= first_rx_desc_addr;
          `RDW_REG_SLOT_ADDR:  prdata <= slot_addr;
          `RDW_REG_STATE:      prdata <= {23'h0, err_frozen, redirect, exact_pend, state, ~close_ready};
          `RDW_REG_LAST_WORD:  prdata <= last_word;
          `RDW_REG_BRANCH:     prdata <= channel_status_slot;
          default:             prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Error accumulation per frame
  wire frame_close = close_take && frame_mode && !exact_fill &&
                     (close_cause == `RDW_CAUSE_FRAME_END || close_cause == `RDW_CAUSE_PAUSE ||
                      close_cause == `RDW_CAUSE_FAST_ABT);
  wire exact_close = (state == ST_WDESC2) && mem_ack;
  wire frame_done  = frame_close || exact_close || (close_take && !frame_mode &&
                     close_cause != `RDW_CAUSE_FILL);

  always @(posedge clk) begin
    if (reset) begin
      err_acc    <= 8'h00;
      err_frozen <= 1'b0;
    end else if (frame_done) begin
      // A report in the closing cycle opens the next frame, not lost
      err_acc    <= {3'b000, err_valid & check_error_flag, err_valid & partial_octet_flag,
                     err_valid & oversize_flag, 1'b0, err_valid & overrun_flag}; // RULE_17
      err_frozen <= err_valid & overrun_flag; // RULE_16
    end else if (err_valid && !err_frozen) begin
      err_acc[`RDW_BIT_CHECK]    <= err_acc[`RDW_BIT_CHECK]    | check_error_flag;   // RULE_12 RULE_17
      err_acc[`RDW_BIT_PARTIAL]  <= err_acc[`RDW_BIT_PARTIAL]  | partial_octet_flag; // RULE_13
      err_acc[`RDW_BIT_OVERSIZE] <= err_acc[`RDW_BIT_OVERSIZE] | oversize_flag;      // RULE_14
      err_acc[`RDW_BIT_OVERRUN]  <= err_acc[`RDW_BIT_OVERRUN]  | overrun_flag;       // RULE_16
      err_frozen <= overrun_flag; // RULE_16
    end
  end

  // Redirect latch; a command in the same cycle as a close still counts
  always @(posedge clk) begin
    if (reset)
      redirect <= 1'b0;
    else if (redirect_cmd && (state != ST_IDLE || close_take))
      redirect <= 1'b1; // RULE_20
    else if (state == ST_BRANCH)
      redirect <= 1'b0;
  end

  // Write-back sequencer
  always @(posedge clk) begin
    if (reset) begin
      state               <= ST_IDLE;
      mem_req             <= 1'b0;
      mem_addr            <= 32'h0000_0000;
      mem_wdata           <= 32'h0000_0000;
      branch_valid        <= 1'b0;
      branch_addr         <= 32'h0000_0000;
      frame_end_int_flag  <= 1'b0;
      fault_int           <= 1'b0;
      channel_status_slot <= 32'h0000_0000;
      last_word           <= 32'h0000_0000;
      exact_pend          <= 1'b0;
      pend_status         <= 8'h00;
      desc_addr           <= 32'h0000_0000;
      next_ptr            <= 32'h0000_0000;
      next2_ptr           <= 32'h0000_0000;
      word2               <= 32'h0000_0000;
      word2_last          <= 1'b0;
      word2_status        <= 8'h00;
    end else begin
      branch_valid       <= 1'b0;
      frame_end_int_flag <= 1'b0;
      fault_int          <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (close_take) begin
            desc_addr    <= close_desc_addr;
            next_ptr     <= close_next_ptr;
            next2_ptr    <= close_next2_ptr;
            exact_pend   <= exact_fill; // RULE_02
            pend_status  <= exact_status;
            word2_last   <= next_last;
            word2_status <= next_status;
            mem_req      <= 1'b1;
            mem_addr     <= close_desc_addr + `RDW_DESC_W2_OFS; // RULE_24
            mem_wdata    <= pack_word(next_last, stored_byte_count, next_status); // RULE_09 RULE_10
            state        <= ST_WDESC;
          end
        end
        ST_WDESC: begin
          if (mem_ack) begin
            last_word <= mem_wdata;
            frame_end_int_flag <= word2_last; // RULE_05
            fault_int <= (word2_status != `RDW_STAT_OK) &&
                         (word2_status != `RDW_STAT_SHORT_OK); // RULE_10 RULE_06 RULE_07
            if (exact_pend && !redirect) begin
              // Empty descriptor that carries only the frame end
              mem_addr  <= next_ptr + `RDW_DESC_W2_OFS; // RULE_02
              mem_wdata <= pack_word(1'b1, 13'h0000, pend_status);
              word2     <= pack_word(1'b1, 13'h0000, pend_status);
              state     <= ST_WDESC2;
            end else begin
              mem_addr  <= slot_addr; // RULE_08
              mem_wdata <= redirect ? first_rx_desc_addr : next_ptr; // RULE_20
              state     <= ST_WSLOT;
            end
          end
        end
        ST_WDESC2: begin
          if (mem_ack) begin
            last_word <= word2;
            frame_end_int_flag <= 1'b1;
            fault_int <= (pend_status != `RDW_STAT_OK) && (pend_status != `RDW_STAT_SHORT_OK);
            mem_addr  <= slot_addr;
            mem_wdata <= redirect ? first_rx_desc_addr : next2_ptr;
            state     <= ST_WSLOT;
          end
        end
        ST_WSLOT: begin
          if (mem_ack) begin
            mem_req             <= 1'b0;
            channel_status_slot <= mem_wdata; // RULE_08
            branch_addr         <= mem_wdata;
            state               <= ST_BRANCH;
          end
        end
        ST_BRANCH: begin
          branch_valid <= 1'b1; // RULE_08
          exact_pend   <= 1'b0;
          state        <= ST_IDLE;
        end
        default: begin
          mem_req <= 1'b0;
          state   <= ST_IDLE;
        end
      endcase
    end
  end

  // Lane order of incoming data words; little endian passes straight
  always @(posedge clk) begin
    if (reset) begin
      data_word_valid <= 1'b0;
      data_word       <= 32'h0000_0000;
    end else begin
      data_word_valid <= rx_word_valid;
      if (rx_word_valid)
        data_word <= big_endian ? {rx_word[7:0], rx_word[15:8], rx_word[23:16], rx_word[31:24]} :
                                  rx_word; // RULE_22
    end
  end

endmodule // rdw_writeback

// >>> test/rdw_mem_model.sv
// Shared memory model that answers descriptor and slot writes
`timescale 1ns/1ps
module rdw_mem_model (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Write port
  input  wire        mem_req,
  input  wire [31:0] mem_addr,
  input  wire [31:0] mem_wdata,
  output reg         mem_ack,
  // Answer delay in cycles
  input  wire [3:0]  lat
);
  logic [31:0] wa[$];
  logic [31:0] wd[$];
  int          cnt;

  // Host only owns words 1, 3 and 4; sizes stay multiples of four
  always @(posedge clk) begin
    if (reset || !mem_req || mem_ack) begin
      mem_ack <= 1'b0;
      cnt     <= 0;
    end else if (cnt >= lat) begin
      mem_ack <= 1'b1;
      wa.push_back(mem_addr);
      wd.push_back(mem_wdata);
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // rdw_mem_model

// >>> test/rdw_writeback_sva.sv
// Port assertions for the descriptor write-back block
`timescale 1ns/1ps
`include "rdw_defines.vh"
module rdw_writeback_sva (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Close handshake
  input wire logic        close_valid,
  input wire logic        close_ready,
  input wire logic [2:0]  close_cause,
  input wire logic [31:0] close_desc_addr,
  input wire logic [12:0] stored_byte_count,
  // Memory writes, branch and events
  input wire logic        mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic        mem_ack,
  input wire logic        branch_valid,
  input wire logic        frame_end_int_flag,
  input wire logic        fault_int
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire take = close_valid && close_ready;

  a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
    else $error("write request dropped early");
  a_desc_addr: assert property (take |=> mem_req && mem_addr == $past(close_desc_addr) + `RDW_DESC_W2_OFS)
    else $error("wrong descriptor word address");
  a_word_layout: assert property (take |=> mem_wdata[30:29] == 2'b10 && mem_wdata[7:0] == 8'h00)
    else $error("bad second word layout");
  a_bit7_zero: assert property (take |=> !mem_wdata[15])
    else $error("status bit 7 set");
  a_count_field: assert property (take |=> mem_wdata[28:16] == $past(stored_byte_count))
    else $error("stored count wrong");
  a_fast_abort: assert property (take && close_cause == `RDW_CAUSE_FAST_ABT |=> mem_wdata[15:8] == 8'h02)
    else $error("fast abort status wrong");
  a_last_only_end: assert property (take && (close_cause == `RDW_CAUSE_FILL ||
    close_cause == `RDW_CAUSE_SYNC_LOSS || close_cause == `RDW_CAUSE_STAGE) |=> !mem_wdata[31])
    else $error("last piece without frame end");
  a_fault_cause: assert property (fault_int |-> $past(mem_ack) &&
    $past(mem_wdata[15:8]) != 8'h00 && $past(mem_wdata[15:8]) != 8'h40)
    else $error("fault event without bad status");
  a_frame_int: assert property (frame_end_int_flag |-> $past(mem_ack) && $past(mem_wdata[31]))
    else $error("frame event without last piece");
  a_branch_soon: assert property (take |-> ##[4:60] branch_valid)
    else $error("no branch after close");
endmodule // rdw_writeback_sva

bind rdw_writeback rdw_writeback_sva chk (.*);

// >>> test/rdw_writeback_tb_top.sv
// Self-checking bench for the descriptor write-back block
`timescale 1ns/1ps
`include "rdw_defines.vh"
module rdw_writeback_tb_top;
  logic        clk, reset, psel, penable, pwrite, pready, pslverr, perr;
  logic        close_valid, close_ready, abort_flag_seen, abort_cmd_seen, redirect_cmd;
  logic        err_valid, check_error_flag, partial_octet_flag, oversize_flag, overrun_flag;
  logic        mem_req, mem_ack, branch_valid, frame_end_int_flag, fault_int, saw_fi, saw_fault;
  logic        rx_word_valid, data_word_valid;
  logic [2:0]  close_cause;
  logic [3:0]  lat;
  logic [7:0]  paddr;
  logic [12:0] stored_byte_count, section_size;
  logic [15:0] frame_bits;
  logic [31:0] pwdata, prdata, close_desc_addr, close_next_ptr, close_next2_ptr, mem_addr;
  logic [31:0] mem_wdata, branch_addr, rx_word, data_word, rd;
  int          errors, num_checks;

  rdw_writeback dut (.*);
  rdw_mem_model mem (.*);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (close_valid && close_ready) begin
      saw_fi    <= 1'b0;
      saw_fault <= 1'b0;
    end else begin
      if (frame_end_int_flag === 1'b1) saw_fi <= 1'b1;
      if (fault_int === 1'b1) saw_fault <= 1'b1;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  function automatic logic [31:0] dw(input logic l, input logic [12:0] c, input logic [7:0] s);
    return {l, 2'b10, c, s, 8'h00};
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    // Response and read data taken at the ready edge
    perr = pslverr;
    rd   = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic report(input logic ce, po, os, ov);
    @(posedge clk);
    err_valid          <= 1'b1;
    check_error_flag   <= ce;
    partial_octet_flag <= po;
    oversize_flag      <= os;
    overrun_flag       <= ov;
    @(posedge clk);
    err_valid <= 1'b0;
  endtask

  task automatic close(input logic [2:0] cause, input logic [12:0] cnt, size, input logic [15:0] bits,
                       input logic [31:0] exp_w, input logic fi, flt, redir, input logic [31:0] nx);
    mem.wa.delete();
    mem.wd.delete();
    @(posedge clk);
    close_cause       <= cause;
    stored_byte_count <= cnt;
    section_size      <= size;
    frame_bits        <= bits;
    close_valid       <= 1'b1;
    @(posedge clk);
    while (close_ready !== 1'b1)
      @(posedge clk);
    close_valid  <= 1'b0;
    redirect_cmd <= redir;
    @(posedge clk);
    redirect_cmd <= 1'b0;
    while (branch_valid !== 1'b1)
      @(posedge clk);
    check(mem.wa[0], close_desc_addr + `RDW_DESC_W2_OFS);
    check(mem.wd[0], exp_w);
    check(mem.wa[mem.wa.size() - 1], 32'h0000_0800);
    check(mem.wd[mem.wd.size() - 1], nx);
    check(branch_addr, nx);
    check(32'(saw_fi), 32'(fi));
    check(32'(saw_fault), 32'(flt));
  endtask

  task automatic order(input logic [31:0] ctrl, input logic [31:0] exp);
    apb(1'b1, `RDW_REG_CTRL, ctrl);
    rx_word       <= 32'h1122_3344;
    rx_word_valid <= 1'b1;
    @(posedge clk);
    rx_word_valid <= 1'b0;
    @(posedge clk);
    check(data_word, exp);
    check(32'(data_word_valid), 32'h1);
  endtask

  initial begin
    {psel, penable, pwrite, close_valid, abort_flag_seen, abort_cmd_seen, err_valid, redirect_cmd} = '0;
    {check_error_flag, partial_octet_flag, oversize_flag, overrun_flag, rx_word_valid} = '0;
    {paddr, pwdata, rx_word, close_cause, stored_byte_count, section_size, frame_bits} = '0;
    close_desc_addr = 32'h0000_1000;
    close_next_ptr  = 32'h0000_2000;
    close_next2_ptr = 32'h0000_3000;
    {lat, errors, num_checks} = '0;
    reset = 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    apb(1'b0, `RDW_REG_CTRL, 32'h0);
    check(rd, 32'(`RDW_CTRL_RESET));
    apb(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
    check(32'(perr), 32'h1);
    apb(1'b1, `RDW_REG_BRANCH, 32'hFFFF_FFFF);
    apb(1'b0, `RDW_REG_BRANCH, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, `RDW_REG_SLOT_ADDR, 32'h0000_0800);
    apb(1'b1, `RDW_REG_FIRST_DESC, 32'h0000_0400);
    apb(1'b0, `RDW_REG_SLOT_ADDR, 32'h0);
    check(rd, 32'h0000_0800);
    // Octet mode masks every reported error
    apb(1'b1, `RDW_REG_CTRL, {29'h0, `RDW_MODE_OCTET_TR});
    report(1'b1, 1'b1, 1'b1, 1'b0);
    close(`RDW_CAUSE_FILL, 16, 16, 128, dw(0, 16, 8'h00), 0, 0, 0, 32'h2000);
    close(`RDW_CAUSE_PAUSE, 16, 16, 128, dw(0, 16, 8'h02), 0, 1, 0, 32'h2000);
    apb(1'b1, `RDW_REG_CTRL, 32'h0);
    lat <= 4'h3;
    report(1'b1, 1'b1, 1'b0, 1'b0);
    close(`RDW_CAUSE_FRAME_END, 10, 64, 80, dw(1, 10, 8'h18), 1, 1, 0, 32'h2000);
    close(`RDW_CAUSE_FRAME_END, 2, 64, 32, dw(1, 2, 8'h40), 1, 0, 0, 32'h2000);
    report(1'b0, 1'b0, 1'b0, 1'b1);
    report(1'b1, 1'b0, 1'b1, 1'b0);
    close(`RDW_CAUSE_FRAME_END, 20, 64, 160, dw(1, 20, 8'h01), 1, 1, 0, 32'h2000);
    abort_flag_seen <= 1'b1;
    close(`RDW_CAUSE_FRAME_END, 8, 64, 64, dw(1, 8, 8'h02), 1, 1, 0, 32'h2000);
    {abort_flag_seen, abort_cmd_seen} <= 2'b01;
    close(`RDW_CAUSE_FRAME_END, 8, 64, 64, dw(1, 8, 8'h02), 1, 1, 0, 32'h2000);
    apb(1'b1, `RDW_REG_CTRL, {29'h0, `RDW_MODE_FLAG_TR});
    close(`RDW_CAUSE_FRAME_END, 8, 64, 64, dw(1, 8, 8'h00), 1, 0, 0, 32'h2000);
    abort_cmd_seen <= 1'b0;
    apb(1'b1, `RDW_REG_CTRL, 32'h8);
    close(`RDW_CAUSE_FRAME_END, 2, 64, 32, dw(1, 2, 8'h00), 1, 0, 0, 32'h2000);
    close(`RDW_CAUSE_FRAME_END, 16, 16, 128, dw(0, 16, 8'h00), 1, 0, 0, 32'h3000);
    check(mem.wa[1], 32'h0000_2004);
    check({mem.wd[1][31:16], 16'h0}, 32'hC000_0000);
    apb(1'b1, `RDW_REG_CTRL, 32'h10);
    close(`RDW_CAUSE_FRAME_END, 4, 64, 48, dw(1, 4, 8'h40), 1, 0, 0, 32'h2000);
    apb(1'b1, `RDW_REG_CTRL, {29'h0, `RDW_MODE_BIT_TR});
    report(1'b0, 1'b1, 1'b0, 1'b0);
    close(`RDW_CAUSE_FRAME_END, 8, 64, 66, dw(1, 8, 8'h08), 1, 1, 0, 32'h2000);
    apb(1'b1, `RDW_REG_CTRL, {29'h0, `RDW_MODE_V110});
    lat <= 4'h1;
    close(`RDW_CAUSE_FAST_ABT, 4, 16, 0, dw(0, 4, 8'h02), 0, 1, 0, 32'h2000);
    close(`RDW_CAUSE_SYNC_LOSS, 8, 16, 0, dw(0, 8, 8'h20), 0, 1, 0, 32'h2000);
    close(`RDW_CAUSE_STAGE, 12, 16, 0, dw(0, 12, 8'h01), 0, 1, 0, 32'h2000);
    close(`RDW_CAUSE_FILL, 16, 16, 0, dw(0, 16, 8'h00), 0, 0, 1, 32'h0000_0400);
    apb(1'b0, `RDW_REG_BRANCH, 32'h0);
    check(rd, 32'h0000_0400);
    apb(1'b0, `RDW_REG_LAST_WORD, 32'h0);
    check(rd, dw(0, 16, 8'h00));
    order(32'h0, 32'h1122_3344);
    order(32'h20, 32'h4433_2211);
    give_verdict();
  end

  // Whole run needs a few hundred cycles
  initial begin
    #(30000 * 4);
    errors++;
    give_verdict();
  end
endmodule // rdw_writeback_tb_top
